// file: hw/add_instruction_execute.sv
// Operation
// - literal add: accumulator plus literal, five flags
// - file add: sum to accumulator or register
// - access bit picks access bank or bank
// - extended set, access bit clear, low address: indexed offset
`timescale 1ns/1ps
`default_nettype none

module add_instruction_execute
  import add_exec_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // instruction word
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  output logic             o_instr_ready,
  // core configuration
  input  wire logic        i_ext_set_en,
  input  wire logic [3:0]  i_bank_ptr,
  input  wire logic [11:0] i_index_base,
  // data memory port
  output logic             o_mem_re,
  output logic             o_mem_we,
  output logic [11:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  // accumulator and flags
  output logic [7:0]       o_accum,
  output logic             o_flag_we,
  output logic             o_flag_neg,
  output logic             o_flag_signed_wrap,
  output logic             o_flag_carry,
  output logic             o_flag_nibble_carry,
  output logic             o_flag_zero
);

  // ****************************************
  // phase sequencer
  // ****************************************
  phase_t phase;
  phase_t next_phase;

  always_comb begin
    case (phase)
      PH_DECODE:  next_phase = PH_READ;
      PH_READ:    next_phase = PH_PROCESS;
      PH_PROCESS: next_phase = PH_WRITE;
      default:    next_phase = PH_DECODE;
    endcase
  end

  // free running so every instruction takes exactly four phases
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase <= PH_DECODE;
    end else begin
      phase <= next_phase;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  wire [7:0] f_addr     = i_instr[7:0];
  wire       is_lit_dec = (i_instr[15:TOP_BYTE_LSB] == LIT_ADD_TOP);
  wire       is_fil_dec = (i_instr[15:FILE_TOP_LSB] == FILE_ADD_TOP);
  wire       take       = (phase == PH_DECODE) && i_instr_valid;
  wire       use_index  = i_ext_set_en && !i_instr[ACCESS_BIT]
                          && (f_addr <= INDEXED_MAX);
  wire [3:0] acc_bank   = (f_addr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HI_BANK;
  wire [11:0] idx_addr  = i_index_base + {4'h0, f_addr};
  wire [11:0] bank_addr = {i_bank_ptr, f_addr};
  wire [11:0] accs_addr = {acc_bank, f_addr};
  wire [11:0] next_addr = use_index ? idx_addr
                        : (i_instr[ACCESS_BIT] ? bank_addr
                                               : accs_addr);

  assign o_instr_ready = (phase == PH_DECODE);

  logic       op_lit;
  logic       op_file;
  logic       dest_file;
  logic [7:0] literal;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      op_lit     <= 1'b0;
      op_file    <= 1'b0;
      dest_file  <= 1'b0;
      literal    <= 8'h00;
      o_mem_addr <= ADDR_RESET;
    end else if (phase == PH_DECODE) begin
      op_lit    <= take && is_lit_dec;
      op_file   <= take && is_fil_dec;
      dest_file <= i_instr[DEST_BIT];
      literal   <= i_instr[7:0];
      if (take && is_fil_dec) begin
        o_mem_addr <= next_addr;
      end
    end
  end

  // ****************************************
  // operand read and process
  // ****************************************
  // memory answers one cycle after the read strobe
  // strobes gated by reset: phase regs only clear at the next clock edge
  assign o_mem_re = (phase == PH_READ) && op_file && i_rst_n;

  wire [7:0] operand = op_lit ? literal : i_mem_rdata;
  wire [7:0] sum;
  wire       c_sum;
  wire       dc_sum;
  wire       ov_sum;
  wire       n_sum;
  wire       z_sum;

  add8_flags adder (
    .i_a            (o_accum),
    .i_b            (operand),
    .o_sum          (sum),
    .o_carry        (c_sum),
    .o_nibble_carry (dc_sum),
    .o_signed_wrap  (ov_sum),
    .o_neg          (n_sum),
    .o_zero         (z_sum)
  );

  logic [7:0] result;
  logic [4:0] flags;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      result <= 8'h00;
      flags  <= 5'h00;
    end else if (phase == PH_PROCESS) begin
      result <= sum;
      flags  <= {n_sum, ov_sum, c_sum, dc_sum, z_sum};
    end
  end

  // ****************************************
  // write to destination
  // ****************************************
  wire wr_phase  = (phase == PH_WRITE);
  wire acc_write = wr_phase && (op_lit || (op_file && !dest_file));

  assign o_mem_we  = wr_phase && op_file && dest_file && i_rst_n;
  assign o_flag_we = wr_phase && (op_lit || op_file) && i_rst_n;

  assign o_mem_wdata         = result;
  assign o_flag_neg          = flags[4];
  assign o_flag_signed_wrap  = flags[3];
  assign o_flag_carry        = flags[2];
  assign o_flag_nibble_carry = flags[1];
  assign o_flag_zero         = flags[0];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_accum <= ACCUM_RESET;
    end else if (acc_write) begin
      o_accum <= result;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_LIT_SUM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_lit_dec) |-> ##4
      (o_accum == 8'($past(o_accum, 4) + $past(i_instr[7:0], 4))))
    else $error("literal add left wrong accumulator");

  AST_FILE_TO_REG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec && i_instr[DEST_BIT]) |-> ##3
      (o_mem_we && o_flag_we && o_mem_wdata == 8'(o_accum + $past(i_mem_rdata, 1))))
    else $error("file add did not write register sum");

  AST_FILE_TO_ACC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec && !i_instr[DEST_BIT]) |-> ##3 (!o_mem_we) ##1
      (o_accum == $past(o_mem_wdata, 1)))
    else $error("file add to accumulator misrouted");

  AST_BANK_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec && i_instr[ACCESS_BIT]) |=>
      (o_mem_addr == {$past(i_bank_ptr), $past(i_instr[7:0])}))
    else $error("bank address wrong");

  AST_ACCESS_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec && !i_instr[ACCESS_BIT]
     && !(i_ext_set_en && i_instr[7:0] <= INDEXED_MAX)) |=>
      (o_mem_addr[7:0] == $past(i_instr[7:0])
       && o_mem_addr[11:8] == (($past(i_instr[7:0]) < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                                                                    : ACCESS_HI_BANK)))
    else $error("access bank address wrong");

  AST_INDEXED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec && i_ext_set_en && !i_instr[ACCESS_BIT]
     && i_instr[7:0] <= INDEXED_MAX) |=>
      (o_mem_addr == 12'($past(i_index_base) + {4'h0, $past(i_instr[7:0])})))
    else $error("indexed offset address wrong");

  AST_FOUR_PHASE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && (is_lit_dec || is_fil_dec)) |-> !o_flag_we [*3] ##1 o_flag_we ##1
      (o_instr_ready && !o_flag_we))
    else $error("add did not finish in four phases");

  AST_READ_PHASE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_fil_dec) |=> o_mem_re ##1 !o_mem_re)
    else $error("operand read not in second phase");

  AST_LIT_NO_MEM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && is_lit_dec) |=> !o_mem_re ##2 (!o_mem_we && o_flag_we))
    else $error("literal add touched data memory");

  AST_RESET_QUIET: assert property (@(posedge i_clk)
    !i_rst_n |-> (!o_mem_we && !o_flag_we) ##1
      (o_instr_ready && o_accum == ACCUM_RESET && o_mem_addr == ADDR_RESET))
    else $error("reset did not quiet the sequencer");

endmodule

`default_nettype wire

// file: hw/add_exec_pkg.sv
package add_exec_pkg;

  // ****************************************
  // opcode patterns and field positions
  // ****************************************
  localparam logic [7:0]  LIT_ADD_TOP     = 8'h0f;
  localparam logic [5:0]  FILE_ADD_TOP    = 6'h09;
  localparam int          TOP_BYTE_LSB    = 8;
  localparam int          FILE_TOP_LSB    = 10;
  localparam int          DEST_BIT        = 9;
  localparam int          ACCESS_BIT      = 8;

  // ****************************************
  // addressing
  // ****************************************
  localparam logic [7:0]  INDEXED_MAX     = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  ACCUM_RESET     = 8'h00;
  localparam logic [11:0] ADDR_RESET      = 12'h000;

  // four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

endpackage

// file: hw/add8_flags.sv
`timescale 1ns/1ps
`default_nettype none

module add8_flags (
  // operands
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  // sum and flags
  output logic      [7:0] o_sum,
  output logic            o_carry,
  output logic            o_nibble_carry,
  output logic            o_signed_wrap,
  output logic            o_neg,
  output logic            o_zero
);

  wire [8:0] full_sum = {1'b0, i_a} + {1'b0, i_b};
  wire [4:0] low_sum  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};

  assign o_sum          = full_sum[7:0];
  assign o_carry        = full_sum[8];
  assign o_nibble_carry = low_sum[4];
  // wrap only when both operands share a sign the sum lacks
  assign o_signed_wrap  = (i_a[7] == i_b[7]) && (full_sum[7] != i_a[7]);
  assign o_neg          = full_sum[7];
  assign o_zero         = (full_sum[7:0] == 8'h00);

endmodule

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import add_exec_pkg::*;
  // **********
  // design and clock
  // **********
  logic        i_clk, i_rst_n, i_instr_valid, i_ext_set_en;
  logic [15:0] i_instr;
  logic [3:0]  i_bank_ptr;
  logic [11:0] i_index_base;
  logic [7:0]  i_mem_rdata;
  logic        o_instr_ready, o_mem_re, o_mem_we, o_flag_we;
  logic        o_flag_neg, o_flag_signed_wrap, o_flag_carry, o_flag_nibble_carry, o_flag_zero;
  logic [11:0] o_mem_addr;
  logic [7:0]  o_mem_wdata, o_accum, acc;
  int          n_fail, checks_done;
  add_instruction_execute dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready), .i_ext_set_en(i_ext_set_en),
    .i_bank_ptr(i_bank_ptr), .i_index_base(i_index_base), .o_mem_re(o_mem_re),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .o_accum(o_accum), .o_flag_we(o_flag_we),
    .o_flag_neg(o_flag_neg), .o_flag_signed_wrap(o_flag_signed_wrap),
    .o_flag_carry(o_flag_carry), .o_flag_nibble_carry(o_flag_nibble_carry),
    .o_flag_zero(o_flag_zero));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // **********
  // rows: word, read data, ext, bank, base, expected address
  // **********
  typedef struct {
    logic [15:0] instr;
    logic [7:0]  rdata;
    logic        ext;
    logic [3:0]  bank;
    logic [11:0] base;
    logic [11:0] addr;
  } row_t;
  row_t rows [13] = '{
    '{16'h0f15, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000},
    '{16'h0f02, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000},
    '{16'h2534, 8'hc2, 1'b0, 4'h5, 12'h000, 12'h534},
    '{16'h265f, 8'h27, 1'b1, 4'h0, 12'h200, 12'h25f},
    '{16'h2660, 8'h28, 1'b1, 4'h0, 12'h200, 12'hf60},
    '{16'h245f, 8'h80, 1'b0, 4'h0, 12'h200, 12'h05f},
    '{16'h0f27, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000},
    '{16'h27ff, 8'hff, 1'b0, 4'hf, 12'h000, 12'hfff},
    '{16'h2410, 8'h01, 1'b1, 4'h0, 12'hfff, 12'h00f},
    '{16'h2503, 8'h01, 1'b1, 4'h7, 12'h200, 12'h703},
    '{16'h2012, 8'h55, 1'b0, 4'h3, 12'h000, 12'h000},
    '{16'h2470, 8'h10, 1'b0, 4'h0, 12'h000, 12'hf70},
    '{16'h0b12, 8'h00, 1'b0, 4'h0, 12'h000, 12'h000}};
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one word through all four phases; waits for decode itself
  task automatic run(input row_t r);
    logic       fa, la, d;
    logic [7:0] op;
    logic [8:0] s;
    logic [4:0] h;
    int         k;
    fa = (r.instr[15:FILE_TOP_LSB] == FILE_ADD_TOP);
    la = (r.instr[15:TOP_BYTE_LSB] == LIT_ADD_TOP);
    d = r.instr[DEST_BIT];
    op = fa ? r.rdata : r.instr[7:0];
    s = {1'b0, acc} + {1'b0, op};
    h = {1'b0, acc[3:0]} + {1'b0, op[3:0]};
    @(posedge i_clk);
    i_instr <= r.instr;
    i_instr_valid <= 1'b1;
    i_ext_set_en <= r.ext;
    i_bank_ptr <= r.bank;
    i_index_base <= r.base;
    i_mem_rdata <= ~r.rdata;
    k = 0;
    @(negedge i_clk);
    while (o_instr_ready !== 1'b1 && k < 8) begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    @(negedge i_clk);
    chk(o_mem_re === fa && o_instr_ready === 1'b0, "read strobe");
    if (fa) chk(o_mem_addr === r.addr, "address");
    // true operand only in the process cycle, so an early sample shows up
    @(posedge i_clk);
    i_mem_rdata <= r.rdata;
    @(negedge i_clk);
    chk(o_mem_re === 1'b0 && o_flag_we === 1'b0, "process phase");
    @(posedge i_clk);
    i_mem_rdata <= ~r.rdata;
    @(negedge i_clk);
    chk(o_flag_we === (fa | la) && o_mem_we === (fa & d), "strobes");
    if (fa | la) chk({o_flag_neg, o_flag_signed_wrap, o_flag_carry, o_flag_nibble_carry,
      o_flag_zero} === {s[7], (acc[7] == op[7]) && (s[7] != acc[7]), s[8], h[4],
      s[7:0] == 8'h00}, "flags");
    if (fa & d) chk(o_mem_wdata === s[7:0], "write data");
    if (la | (fa & ~d)) acc = s[7:0];
    @(negedge i_clk);
    chk(o_accum === acc && o_instr_ready === 1'b1, "accumulator");
    $display("test %h done", r.instr);
  endtask
  task automatic reset_check();
    acc = ACCUM_RESET;
    chk(o_accum === ACCUM_RESET && o_mem_addr === ADDR_RESET, "reset values");
    chk(o_instr_ready === 1'b1 && {o_mem_re, o_mem_we, o_flag_we} === 3'b000, "reset");
    chk({o_mem_wdata, o_flag_neg, o_flag_signed_wrap, o_flag_carry, o_flag_nibble_carry,
      o_flag_zero} === 13'h0000, "reset data");
    $display("test reset done");
  endtask
  // **********
  // sequence
  // **********
  initial begin
    {i_rst_n, i_instr_valid, i_ext_set_en, i_bank_ptr} = '0;
    {i_instr, i_index_base, i_mem_rdata} = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    reset_check();
    foreach (rows[i]) run(rows[i]);
    // reset in mid-instruction drops the pending write
    @(posedge i_clk);
    i_instr <= 16'h2634;
    i_instr_valid <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    chk(o_mem_we === 1'b0 && o_flag_we === 1'b0, "write during reset");
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_instr_valid <= 1'b0;
    @(negedge i_clk);
    reset_check();
    run(rows[0]);
    report_and_stop();
  end
  initial begin
    repeat (1000) @(posedge i_clk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
